// ---- core/cycle_realtime_calculator.sv ----
// Purpose: period source, cycle signal, frequency, 32 calculators
//          and their level-crossing trigger detectors
// Assumes: samples and counter value synchronous to ref_clk
// Notes:   one shared engine walks all slots per sample and per
//          period; a sample still pending when a period starts closing is lost
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module cycle_realtime_calculator (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_we,
	input  wire logic             reg_re,
	output      logic [31:0]      reg_rdata,
	input  wire rtc_pkg::sample_t smp,
	input  wire logic [31:0]      cnt_freq,
	output      logic             cyc_out,
	output      logic [31:0]      freq_out,
	output      rtc_pkg::result_t result,
	output      rtc_pkg::event_t  event_note,
	output      rtc_pkg::trig_t   trig,
	output      logic [7:0]       ext_mask,
	output      logic [31:0]      ext_sweep_max,
	output      logic             irq
);
	typedef struct packed {
		logic                          src_cd;
		logic [2:0]                    det_chan;
		logic                          en;
		logic [31:0]                   interval;
		logic signed [15:0]            level;
		logic [15:0]                   hyst;
		logic [15:0]                   cyc_count;
		logic [4:0]                    sel;
		logic [3:0]                    irq_st;
		logic [3:0]                    irq_mask;
		logic [7:0]                    ext_mask;
		logic [31:0]                   sweep_max;
		rtc_pkg::slot_cfg_t [31:0]     cfg;
		logic [31:0][31:0]             tlev;
		logic [5:0]                    pre;
		logic [31:0]                   now_us;
		logic [31:0]                   el_us;
		logic [31:0]                   span_us;
		logic [31:0]                   last_cross;
		logic                          armed;
		logic [31:0]                   period;
		logic [15:0]                   eff;
		logic [15:0]                   ncyc;
		logic                          halted;
		logic                          bnd_pend;
		logic                          smp_pend;
		logic [2:0]                    smp_chan;
		logic [7:0][15:0]              last_val;
		logic                          freq_pend;
		logic [31:0]                   freq;
		rtc_pkg::eng_t                 eng;
		logic [4:0]                    slot;
		logic signed [31:0]            val;
		logic [15:0]                   root;
		logic [3:0]                    sbit;
		logic                          cyc;
		rtc_pkg::result_t              res;
		rtc_pkg::event_t               ev;
		rtc_pkg::trig_t                trg;
		logic [31:0]                   rdata;
		logic [31:0]                   ext_max;
		logic                          irq;
	} st_t;

	st_t                s, n;
	rtc_pkg::acc_t      acc_rd, acc_wr;
	rtc_pkg::slot_cfg_t c;
	logic               mem_we;
	logic [135:0]       mem_rdata;
	logic               div_start, div_done;
	logic [47:0]        div_num, div_den, div_quot;
	logic [3:0]         irq_set;
	logic               tick, bnd;
	logic signed [17:0] xs, hi_th, lo_th;
	logic [31:0]        per, iv;
	logic [47:0]        span_est;
	logic signed [31:0] term, lev, prv;
	logic [15:0]        trial;
	logic [31:0]        eff_cfg;

	assign acc_rd = rtc_pkg::acc_t'(mem_rdata);
	assign c      = s.cfg[s.slot];
	assign lev    = $signed(s.tlev[s.slot]);
	assign prv    = acc_rd.prev;

	always_comb begin
		// Defaults: pulses drop, everything else holds
		n = s;
		n.res.valid = 1'b0;
		n.ev = '0;
		n.trg.valid = 1'b0;
		n.rdata = 32'h00000000;
		irq_set = 4'h0;
		mem_we = 1'b0;
		acc_wr = '0;
		div_start = 1'b0;
		div_num = '0;
		div_den = '0;
		bnd = 1'b0;
		per = s.now_us - s.last_cross;
		span_est = s.eff * per;
		term = 32'h00000000;
		trial = 16'h0000;
		eff_cfg = (s.cyc_count == 16'h0000) ? 32'h1 : {16'h0, s.cyc_count};
		xs = 18'(smp.data);
		hi_th = 18'(s.level) + $signed({2'b00, s.hyst});
		lo_th = 18'(s.level) - $signed({2'b00, s.hyst});
		// Clamp keeps the timer inside its legal span
		iv = s.interval;
		if (iv < `TIMER_MIN_US) iv = `TIMER_MIN_US;
		if (iv > `TIMER_MAX_US) iv = `TIMER_MAX_US;

		// Microsecond time base
		tick = (s.pre == 6'(`US_CYCLES - 1));
		n.pre = tick ? 6'h00 : s.pre + 6'h01;
		if (tick) n.now_us = s.now_us + 32'h1;

		// Sample capture; last values feed the product calculation
		if (smp.valid) begin
			n.last_val[smp.chan] = smp.data;
			n.smp_pend = 1'b1;
			n.smp_chan = smp.chan;
		end

		// Cycle detect on the selected channel with hysteresis
		if (smp.valid && s.src_cd && smp.chan == s.det_chan) begin
			if (s.armed && xs > hi_th) begin
				n.armed = 1'b0;
				n.period = per;
				n.last_cross = s.now_us;
				n.freq_pend = 1'b1;
				if (per > `PERIOD_MAX_US) begin
					n.halted = 1'b1;
					n.ev = '{1'b1, rtc_pkg::ev_over, s.now_us};
					irq_set[`IRQ_OVER] = 1'b1;
				end else begin
					n.halted = 1'b0;
					if (per >= `PERIOD_MIN_US) begin
						n.eff = eff_cfg[15:0];
					end else if (span_est < `PERIOD_MIN_US) begin
						n.eff = s.eff[15] ? 16'hffff : {s.eff[14:0], 1'b0};
						n.ev = '{1'b1, rtc_pkg::ev_raise, s.now_us};
						irq_set[`IRQ_RAISE] = 1'b1;
					end
					// Count cycles toward one calculation output
					if ({16'h0, s.ncyc} + 32'h1 >= {16'h0, n.eff}) begin
						n.ncyc = 16'h0000;
						bnd = 1'b1;
					end else begin
						n.ncyc = s.ncyc + 16'h0001;
					end
				end
			end else if (xs < lo_th) begin
				n.armed = 1'b1;
			end
		end
		// Signal gone quiet: the period is already too long
		if (s.src_cd && !s.halted && tick && per > `PERIOD_MAX_US) begin
			n.halted = 1'b1;
			n.ev = '{1'b1, rtc_pkg::ev_over, s.now_us};
			irq_set[`IRQ_OVER] = 1'b1;
		end
		// Interval timer as period source
		if (!s.src_cd && tick && s.el_us + 32'h1 >= iv) bnd = 1'b1;

		// Period boundary drives the square wave and the calculations
		if (bnd) begin
			n.cyc = 1'b1;
			n.span_us = s.el_us;
			n.el_us = 32'h0;
			irq_set[`IRQ_BND] = 1'b1;
			if (s.en && !s.halted) n.bnd_pend = 1'b1;
		end else if (tick) begin
			n.el_us = s.el_us + 32'h1;
			if (s.el_us >= (s.span_us >> 1)) n.cyc = 1'b0;
		end

		// Calculation engine
		case (s.eng)
			rtc_pkg::st_clr: begin
				mem_we = 1'b1;
				acc_wr = '{32'h0, 48'h0, 24'h0, 16'sh7fff, -16'sh8000};
				n.slot = s.slot + 5'h01;
				if (s.slot == 5'h1f) n.eng = rtc_pkg::st_idle;
			end
			rtc_pkg::st_idle: begin
				n.slot = 5'h00;
				if (s.bnd_pend) begin
					n.bnd_pend = 1'b0;
					n.smp_pend = 1'b0;
					n.eng = rtc_pkg::st_fin_rd;
				end else if (s.freq_pend && s.period != 32'h0) begin
					n.freq_pend = 1'b0;
					div_start = 1'b1;
					div_num = `FREQ_NUM_MHZ;
					div_den = {16'h0, s.period};
					n.eng = rtc_pkg::st_freq;
				end else if (s.smp_pend) begin
					n.smp_pend = 1'b0;
					n.eng = rtc_pkg::st_upd_rd;
				end
			end
			rtc_pkg::st_freq: begin
				if (div_done) begin
					n.freq = div_quot[31:0];
					n.eng = rtc_pkg::st_idle;
				end
			end
			rtc_pkg::st_upd_rd: n.eng = rtc_pkg::st_upd_wr;
			rtc_pkg::st_upd_wr: begin
				// Fold the pending sample into every statistics slot whose chan_a is its channel
				acc_wr = acc_rd;
				case (c.func)
					rtc_pkg::fn_rms, rtc_pkg::fn_energy:
						term = 32'(smp_x2(s.last_val[s.smp_chan]));
					rtc_pkg::fn_mean_of_product:
						term = $signed(s.last_val[s.smp_chan])
							* $signed(s.last_val[c.chan_b]);
					default: term = 32'($signed(s.last_val[s.smp_chan]));
				endcase
				if (c.chan_a == s.smp_chan && c.func >= rtc_pkg::fn_rms
					&& c.func <= rtc_pkg::fn_mean_of_product) begin
					mem_we = 1'b1;
					acc_wr.n = acc_rd.n + 24'h1;
					acc_wr.sum = acc_rd.sum + 48'(term);
					if ($signed(s.last_val[s.smp_chan]) < acc_rd.mn)
						acc_wr.mn = s.last_val[s.smp_chan];
					if ($signed(s.last_val[s.smp_chan]) > acc_rd.mx)
						acc_wr.mx = s.last_val[s.smp_chan];
				end
				n.slot = s.slot + 5'h01;
				n.eng = (s.slot == 5'h1f) ? rtc_pkg::st_idle
					: rtc_pkg::st_upd_rd;
			end
			rtc_pkg::st_fin_rd: n.eng = rtc_pkg::st_fin_calc;
			rtc_pkg::st_fin_calc: begin
				// Close one slot: pick or start its result
				n.eng = rtc_pkg::st_fin_wr;
				case (c.func)
					rtc_pkg::fn_cycle: n.val = {31'h0, s.cyc};
					rtc_pkg::fn_freq:  n.val = s.freq;
					rtc_pkg::fn_cntf:  n.val = cnt_freq;
					rtc_pkg::fn_min:   n.val = 32'(acc_rd.mn);
					rtc_pkg::fn_max:   n.val = 32'(acc_rd.mx);
					rtc_pkg::fn_pkpk:  n.val = 32'(acc_rd.mx) - 32'(acc_rd.mn);
					rtc_pkg::fn_area, rtc_pkg::fn_energy:
						n.val = acc_rd.sum[31:0];
					rtc_pkg::fn_rms, rtc_pkg::fn_mean,
					rtc_pkg::fn_mean_of_product: begin
						n.val = 32'h0;
						if (acc_rd.n != 24'h0) begin
							div_start = 1'b1;
							div_num = acc_rd.sum[47] ? 48'(-acc_rd.sum)
								: acc_rd.sum;
							div_den = {24'h0, acc_rd.n};
							n.eng = rtc_pkg::st_fin_div;
						end
					end
					default: n.val = 32'h0;
				endcase
			end
			rtc_pkg::st_fin_div: begin
				if (div_done) begin
					n.val = acc_rd.sum[47] ? -$signed(div_quot[31:0])
						: $signed(div_quot[31:0]);
					n.root = 16'h0000;
					n.sbit = 4'hf;
					n.eng = (c.func == rtc_pkg::fn_rms)
						? rtc_pkg::st_fin_sqrt : rtc_pkg::st_fin_wr;
				end
			end
			rtc_pkg::st_fin_sqrt: begin
				// Bit-serial square root of the mean square
				trial = s.root | (16'h0001 << s.sbit);
				if ({16'h0, trial} * {16'h0, trial} <= s.val) n.root = trial;
				n.sbit = s.sbit - 4'h1;
				if (s.sbit == 4'h0) begin
					n.val = {16'h0, n.root};
					n.eng = rtc_pkg::st_fin_wr;
				end
			end
			rtc_pkg::st_fin_wr: begin
				mem_we = 1'b1;
				acc_wr = '{s.val, 48'h0, 24'h0, 16'sh7fff, -16'sh8000};
				if (c.func != rtc_pkg::fn_off) begin
					n.res = '{1'b1, s.slot, s.val};
					// Level crossing against the previous result
					if (c.trig_en && (c.trig_fall
						? (prv > lev && s.val <= lev)
						: (prv < lev && s.val >= lev))) begin
						n.trg = '{1'b1, s.slot,
							s.now_us - `TRIG_DELAY_US};
						irq_set[`IRQ_TRIG] = 1'b1;
					end
				end
				n.slot = s.slot + 5'h01;
				n.eng = (s.slot == 5'h1f) ? rtc_pkg::st_idle
					: rtc_pkg::st_fin_rd;
			end
			default: n.eng = rtc_pkg::st_idle;
		endcase

		// Register writes
		if (reg_we) begin
			case (reg_addr)
				`OFS_CTRL: begin
					n.src_cd = reg_wdata[`CTRL_SRC];
					n.det_chan = reg_wdata[`CTRL_CHAN_LSB +: 3];
					n.en = reg_wdata[`CTRL_EN];
				end
				`OFS_INTERVAL: n.interval = reg_wdata;
				`OFS_LEVEL: begin
					n.level = reg_wdata[15:0];
					n.hyst = reg_wdata[31:16];
				end
				`OFS_CYC_COUNT: begin
					n.cyc_count = reg_wdata[15:0];
					n.eff = (reg_wdata[15:0] == 16'h0) ? 16'h0001
						: reg_wdata[15:0];
				end
				`OFS_IRQ_STAT: n.irq_st = s.irq_st & ~reg_wdata[3:0];
				`OFS_IRQ_MASK: n.irq_mask = reg_wdata[3:0];
				`OFS_SLOT_SEL: n.sel = reg_wdata[4:0];
				`OFS_SLOT_CFG: n.cfg[s.sel] = reg_wdata[11:0];
				`OFS_SLOT_LEVEL: n.tlev[s.sel] = reg_wdata;
				`OFS_EXT_MASK: n.ext_mask = reg_wdata[7:0];
				`OFS_SWEEP_MAX: n.sweep_max = reg_wdata;
				default: ;
			endcase
		end
		// Set wins over a same-cycle clear
		n.irq_st = n.irq_st | irq_set;
		n.irq = |(n.irq_st & n.irq_mask);

		// Trigger users lose the pre-trigger share of their sweep
		n.ext_max = (s.sweep_max > `TRIG_DELAY_US)
			? s.sweep_max - `TRIG_DELAY_US : 32'h0;

		// Register reads, data in the following cycle only
		if (reg_re) begin
			case (reg_addr)
				`OFS_CTRL: n.rdata = {27'h0, s.en, s.det_chan, s.src_cd};
				`OFS_INTERVAL: n.rdata = s.interval;
				`OFS_LEVEL: n.rdata = {s.hyst, s.level};
				`OFS_CYC_COUNT: n.rdata = {16'h0, s.cyc_count};
				`OFS_STATUS: n.rdata = {s.eff, 14'h0, s.cyc, s.halted};
				`OFS_PERIOD: n.rdata = s.period;
				`OFS_FREQ: n.rdata = s.freq;
				`OFS_IRQ_STAT: n.rdata = {28'h0, s.irq_st};
				`OFS_IRQ_MASK: n.rdata = {28'h0, s.irq_mask};
				`OFS_SLOT_SEL: n.rdata = {27'h0, s.sel};
				`OFS_SLOT_CFG: n.rdata = {20'h0, s.cfg[s.sel]};
				`OFS_SLOT_LEVEL: n.rdata = s.tlev[s.sel];
				`OFS_EXT_MASK: n.rdata = {24'h0, s.ext_mask};
				`OFS_SWEEP_MAX: n.rdata = s.sweep_max;
				default: n.rdata = 32'h00000000;
			endcase
		end
	end

	// Square of a sample, kept apart to stay readable
	function automatic logic signed [31:0] smp_x2(input logic [15:0] v);
		smp_x2 = $signed(v) * $signed(v);
	endfunction

	// Engine starts by sweeping the accumulator store clean
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s <= '0;
			s.interval <= `RST_INTERVAL;
			s.cyc_count <= `RST_CYC_COUNT;
			s.eff <= `RST_CYC_COUNT;
			s.sweep_max <= `RST_SWEEP_MAX;
			s.eng <= rtc_pkg::st_clr;
		end else begin
			s <= n;
		end
	end

	slot_mem #(.W(136), .D(`NUM_SLOTS), .AW(5)) u_mem (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.we      (mem_we),
		.waddr   (s.slot),
		.wdata   (acc_wr),
		.raddr   (s.slot),
		.rdata   (mem_rdata)
	);

	seq_div #(.W(48)) u_div (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.start   (div_start),
		.num     (div_num),
		.den     (div_den),
		.quot    (div_quot),
		.done    (div_done)
	);

	// Outputs straight from the state register
	assign reg_rdata     = s.rdata;
	assign cyc_out       = s.cyc;
	assign freq_out      = s.freq;
	assign result        = s.res;
	assign event_note    = s.ev;
	assign trig          = s.trg;
	assign ext_mask      = s.ext_mask;
	assign ext_sweep_max = s.ext_max;
	assign irq           = s.irq;
endmodule // cycle_realtime_calculator

// ---- core/rtc_cfg.svh ----
// Purpose: constants of the cycle and real-time calculator block
// Assumes: 40 MHz reference clock; times kept in microseconds
// Notes:   offsets are byte addresses on the plain register port
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// Clock and time base
`define CLK_HZ          40000000
`define US_CYCLES       (`CLK_HZ / 1000000)
`define TIMER_MIN_MS    1
`define TIMER_MIN_US    (`TIMER_MIN_MS * 1000)
`define TIMER_MAX_S     60
`define TIMER_MAX_US    (`TIMER_MAX_S * 1000000)
`define PERIOD_MAX_MS   250
`define PERIOD_MAX_US   (`PERIOD_MAX_MS * 1000)
`define PERIOD_MIN_US   910
`define TRIG_DELAY_MS   100
`define TRIG_DELAY_US   (`TRIG_DELAY_MS * 1000)
`define FREQ_NUM_MHZ    48'h00003b9aca00
`define NUM_SLOTS       32

// Register offsets
`define OFS_CTRL        8'h00
`define OFS_INTERVAL    8'h04
`define OFS_LEVEL       8'h08
`define OFS_CYC_COUNT   8'h0c
`define OFS_STATUS      8'h10
`define OFS_PERIOD      8'h14
`define OFS_FREQ        8'h18
`define OFS_IRQ_STAT    8'h1c
`define OFS_IRQ_MASK    8'h20
`define OFS_SLOT_SEL    8'h24
`define OFS_SLOT_CFG    8'h28
`define OFS_SLOT_LEVEL  8'h2c
`define OFS_EXT_MASK    8'h30
`define OFS_SWEEP_MAX   8'h34

// Field positions
`define CTRL_SRC        0
`define CTRL_CHAN_LSB   1
`define CTRL_EN         4
`define IRQ_OVER        0
`define IRQ_RAISE       1
`define IRQ_BND         2
`define IRQ_TRIG        3

// Reset values
`define RST_INTERVAL    32'h000003e8
`define RST_CYC_COUNT   16'h0001
`define RST_SWEEP_MAX   32'h00000000
`endif

// ---- core/rtc_pkg.sv ----
// Purpose: types shared by the calculator block
// Assumes: eight analog channels, 32 calculator slots
// Notes:   no constants here; figures live in the cfg header
package rtc_pkg;
	typedef enum logic [3:0] {
		fn_off    = 4'h0, fn_cycle  = 4'h1, fn_freq   = 4'h2,
		fn_rms    = 4'h3, fn_min    = 4'h4, fn_max    = 4'h5,
		fn_mean   = 4'h6, fn_pkpk   = 4'h7, fn_area   = 4'h8,
		fn_energy = 4'h9, fn_mean_of_product = 4'ha, fn_cntf = 4'hb
	} func_t;

	typedef enum logic [9:0] {
		st_clr  = 10'h001, st_idle = 10'h002, st_upd_rd = 10'h004,
		st_upd_wr = 10'h008, st_fin_rd = 10'h010, st_fin_calc = 10'h020,
		st_fin_div = 10'h040, st_fin_sqrt = 10'h080,
		st_fin_wr = 10'h100, st_freq = 10'h200
	} eng_t;

	typedef enum logic [1:0] {
		ev_none = 2'h0, ev_over = 2'h1, ev_raise = 2'h2
	} ev_code_t;

	typedef struct packed {
		logic        trig_en;
		logic        trig_fall;
		logic [2:0]  chan_b;
		logic [2:0]  chan_a;
		func_t       func;
	} slot_cfg_t;

	typedef struct packed {
		logic signed [31:0] prev;
		logic signed [47:0] sum;
		logic        [23:0] n;
		logic signed [15:0] mn;
		logic signed [15:0] mx;
	} acc_t;

	typedef struct packed {
		logic               valid;
		logic        [2:0]  chan;
		logic signed [15:0] data;
	} sample_t;

	typedef struct packed {
		logic        valid;
		ev_code_t    code;
		logic [31:0] stamp;
	} event_t;

	typedef struct packed {
		logic        valid;
		logic [4:0]  slot;
		logic [31:0] value;
	} result_t;

	typedef struct packed {
		logic        valid;
		logic [4:0]  slot;
		logic [31:0] stamp;
	} trig_t;
endpackage

// ---- core/seq_div.sv ----
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: start is a one-cycle pulse while not busy
// Notes:   division by zero returns all ones; done is a pulse
`timescale 1ns/1ps
module seq_div #(
	parameter int W = 48
) (
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic         start,
	input  wire logic [W-1:0] num,
	input  wire logic [W-1:0] den,
	output      logic [W-1:0] quot,
	output      logic         done
);
	typedef struct packed {
		logic         busy;
		logic         done;
		logic [W-1:0] r;
		logic [W-1:0] q;
		logic [W-1:0] d;
		logic [7:0]   cnt;
	} div_st_t;

	div_st_t s, n;
	logic [W:0] tr;

	// One shift-subtract step per cycle
	always_comb begin
		n = s;
		n.done = 1'b0;
		tr = {s.r, s.q[W-1]};
		if (start && !s.busy) begin
			n.busy = 1'b1;
			n.r = '0;
			n.q = num;
			n.d = den;
			n.cnt = 8'(W);
		end else if (s.busy) begin
			if (tr >= {1'b0, s.d}) begin
				n.r = W'(tr - {1'b0, s.d});
				n.q = {s.q[W-2:0], 1'b1};
			end else begin
				n.r = tr[W-1:0];
				n.q = {s.q[W-2:0], 1'b0};
			end
			n.cnt = s.cnt - 8'h01;
			if (s.cnt == 8'h01) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign quot = s.q;
	assign done = s.done;
endmodule // seq_div

// ---- core/slot_mem.sv ----
// Purpose: accumulator store, one word per calculator slot
// Assumes: one write and one read port on the same clock
// Notes:   read data registered; contents undefined until cleared
`timescale 1ns/1ps
module slot_mem #(
	parameter int W  = 136,
	parameter int D  = 32,
	parameter int AW = 5
) (
	input  wire logic          ref_clk,
	input  wire logic          rstn,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output      logic [W-1:0]  rdata
);
	logic [W-1:0] mem [D];

	// No reset on the array: the owner sweeps it clean after reset
	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read port
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule // slot_mem

// ---- sim/cycle_realtime_calculator_asserts.sv ----
// Purpose: port checks of the calculator block
// Assumes: one clock, synchronous active-low reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_checker (
	input wire logic             ref_clk,
	input wire logic             rstn,
	input wire logic [7:0]       reg_addr,
	input wire logic [31:0]      reg_wdata,
	input wire logic             reg_we,
	input wire logic             reg_re,
	input wire logic [31:0]      reg_rdata,
	input wire rtc_pkg::result_t result,
	input wire rtc_pkg::event_t  event_note,
	input wire rtc_pkg::trig_t   trig,
	input wire logic [7:0]       ext_mask,
	input wire logic [31:0]      ext_sweep_max
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Register port: data only after a read, holes read zero
	a_rdata_idle: assert property (!reg_re |=> reg_rdata == 32'h0)
		else $error("read data out of turn");
	a_hole_zero: assert property (reg_re && reg_addr > `OFS_SWEEP_MAX
		|=> reg_rdata == 32'h0) else $error("hole read not zero");
	// Results walk the slots upward, triggers ride with them
	a_slot_order: assert property (
		result.valid |=> !result.valid || result.slot > $past(result.slot))
		else $error("slot order broken");
	a_trig_pairs: assert property (
		trig.valid |-> result.valid && trig.slot == result.slot)
		else $error("trigger without its result");
	// Recorder side follows the sweep and mask registers
	a_sweep_short: assert property (
		reg_we && reg_addr == `OFS_SWEEP_MAX |-> ##2 ext_sweep_max ==
		($past(reg_wdata, 2) > `TRIG_DELAY_US ?
		$past(reg_wdata, 2) - `TRIG_DELAY_US : 32'h0))
		else $error("sweep not shortened");
	a_mask_set: assert property (
		reg_we && reg_addr == `OFS_EXT_MASK |-> ##2
		{24'h0, ext_mask} == ($past(reg_wdata, 2) & 32'h000000ff))
		else $error("extension mask wrong");
	// Event notes carry a known code and last one cycle
	a_event_code: assert property (
		event_note.valid |->
		event_note.code inside {rtc_pkg::ev_over, rtc_pkg::ev_raise})
		else $error("bad event code");
	a_event_pulse: assert property (
		event_note.valid |=> !event_note.valid)
		else $error("event note too long");
endmodule // rtc_checker
bind cycle_realtime_calculator rtc_checker rtc_checker_inst (.ref_clk,
	.rstn, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .result,
	.event_note, .trig, .ext_mask, .ext_sweep_max);

// ---- sim/sample_source.sv ----
// Purpose: analog sample and counter channel source
// Assumes: send is entered just after a rising edge
// Notes:   data shows the inverse of the last value between pulses
`timescale 1ns/1ps
module sample_source (
	input  wire logic       ref_clk,
	output rtc_pkg::sample_t smp,
	output logic [31:0]     cnt_freq
);
	// Idle lines at time zero
	initial begin
		smp = '0;
		cnt_freq = 32'h0000c350;
	end
	// One pulse, then the spacing the engine needs between samples
	task automatic send(input logic [2:0] ch, input logic [15:0] x);
		smp <= '{1'b1, ch, x};
		@(posedge ref_clk);
		smp.valid <= 1'b0;
		smp.data <= ~x;
		repeat (99) @(posedge ref_clk);
	endtask
endmodule // sample_source

// ---- sim/test_cycle_realtime_calculator.sv ----
// Purpose: self-checking bench of the calculator block
// Assumes: 40 MHz clock, samples 100 cycles apart
// Notes:   statistics in timer mode, raises in detect mode
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module test_cycle_realtime_calculator;
	logic             ref_clk = 1'b0;
	logic             rstn = 1'b0;
	logic             reg_we = 1'b0;
	logic             reg_re = 1'b0;
	logic [7:0]       reg_addr = 8'h00;
	logic [31:0]      reg_wdata = 32'h0;
	logic [31:0]      reg_rdata, freq_out, ext_sweep_max, v, cnt_freq;
	logic [7:0]       ext_mask;
	logic             cyc_out, irq;
	rtc_pkg::sample_t smp;
	rtc_pkg::result_t result;
	rtc_pkg::event_t  event_note;
	rtc_pkg::trig_t   trig;
	int               bad_count = 0, checks = 0, raise_n = 0, mx, mn, d;
	int               sum = 0, cyc_n = 0;

	// Free-running clock
	always #12.5 ref_clk = ~ref_clk;
	cycle_realtime_calculator cycle_realtime_calculator_inst (.ref_clk,
		.rstn, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .smp,
		.cnt_freq, .cyc_out, .freq_out, .result, .event_note, .trig,
		.ext_mask, .ext_sweep_max, .irq);
	sample_source sample_source_inst (.ref_clk, .smp, .cnt_freq);
	// Count raise notes away from the edge that launches them
	always @(negedge ref_clk)
		if (event_note.valid === 1'b1 && event_note.code === 2'h2) raise_n++;
	// Cycles since reset release, time base of the stamp model
	always @(posedge ref_clk)
		if (rstn) cyc_n++;

	task automatic chk(input string n, input logic [31:0] lo, hi, s);
		checks++;
		if ((s >= lo && s <= hi) !== 1'b1) begin
			bad_count++;
			$display("unexpected %s expected %0d..%0d seen %0d", n, lo, hi, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		reg_addr <= a;
		reg_wdata <= x;
		reg_we <= 1'b1;
		@(posedge ref_clk);
		reg_we <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge ref_clk);
		reg_re <= 1'b0;
		// Data stand for this one cycle; look mid-cycle
		@(negedge ref_clk);
		q = reg_rdata;
		@(posedge ref_clk);
	endtask
	// Bounded wait for one slot result, then hold it against the model
	task automatic wait_res(input logic [31:0] sl, x, tr);
		int t;
		for (int i = 0; i < 30000; i++) begin
			@(negedge ref_clk);
			if (result.valid === 1'b1) break;
		end
		// Stamp launched one edge before the sample, minus the delay
		t = cyc_n / `US_CYCLES - `TRIG_DELAY_US;
		chk("result_valid", 1, 1, {31'h0, result.valid});
		chk("result_slot", sl, sl, {27'h0, result.slot});
		chk("result_value", x, x, result.value);
		chk("trig_valid", tr, tr, {31'h0, trig.valid});
		if (tr == 1) chk("trig_stamp", t - 1, t, trig.stamp);
	endtask
	task automatic summarize;
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Main sequence: registers, one timer period, then cycle detect
	initial begin
		void'($urandom(71));
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		rd(`OFS_INTERVAL, v);
		chk("interval_reset", `RST_INTERVAL, `RST_INTERVAL, v);
		rd(8'h40, v);
		chk("hole", 32'h0, 32'h0, v);
		wr(`OFS_INTERVAL, 32'h000001f4);
		rd(`OFS_INTERVAL, v);
		// Register keeps the written value; the timer clamps it
		chk("interval_rd", 32'h1f4, 32'h1f4, v);
		wr(`OFS_SWEEP_MAX, 32'h000249f0);
		wr(`OFS_EXT_MASK, 32'h00000081);
		wr(`OFS_SLOT_CFG, 32'h00000805);
		wr(`OFS_SLOT_LEVEL, 32'h00000001);
		wr(`OFS_SLOT_SEL, 32'h00000001);
		wr(`OFS_SLOT_CFG, 32'h00000004);
		wr(`OFS_SLOT_SEL, 32'h00000002);
		wr(`OFS_SLOT_CFG, 32'h0000000b);
		wr(`OFS_SLOT_SEL, 32'h00000003);
		wr(`OFS_SLOT_CFG, 32'h00000006);
		wr(`OFS_IRQ_MASK, 32'h00000004);
		wr(`OFS_CTRL, 32'h00000010);
		mx = 0;
		mn = 32767;
		repeat (250) begin
			d = $urandom_range(30000, 1);
			sample_source_inst.send(3'h0, d[15:0]);
			mx = d > mx ? d : mx;
			mn = d < mn ? d : mn;
			sum += d;
		end
		wait_res(0, mx, 1);
		chk("cycle_high", 1, 1, {31'h0, cyc_out});
		wait_res(1, mn, 0);
		wait_res(2, 32'hc350, 0);
		wait_res(3, sum / 250, 0);
		chk("irq_set", 1, 1, {31'h0, irq});
		chk("sweep_max", 32'hc350, 32'hc350, ext_sweep_max);
		chk("ext_mask", 32'h81, 32'h81, {24'h0, ext_mask});
		@(posedge ref_clk);
		wr(`OFS_IRQ_STAT, 32'h00000004);
		wr(`OFS_IRQ_MASK, 32'h00000000);
		wr(`OFS_LEVEL, 32'h00640000);
		wr(`OFS_CTRL, 32'h00000011);
		for (int i = 0; i < 240; i++)
			sample_source_inst.send(3'h0, (i / 20) % 2 ? 16'h03e8 : 16'hfc18);
		rd(`OFS_PERIOD, v);
		chk("period_us", 32'h63, 32'h65, v);
		chk("freq", `FREQ_NUM_MHZ / 101,
			`FREQ_NUM_MHZ / 99, freq_out);
		chk("raise_notes", 1, 32'hff, raise_n);
		chk("irq_masked", 0, 0, {31'h0, irq});
		summarize();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (90000) @(posedge ref_clk);
		bad_count++;
		summarize();
	end
endmodule // test_cycle_realtime_calculator
